/* hdl/bitbang_consts.vh */
// Constants of the byte-wide bit-bang port: register offsets, mode codes, field positions, counts.
// Assumes inclusion by bare name from the port module.
`ifndef BITBANG_CONSTS_VH
`define BITBANG_CONSTS_VH
`define MODE_RESET        8'h00
`define MODE_ASYNC        8'h01
`define MODE_SYNC         8'h04
`define OFF_MODE          5'h00
`define OFF_DATA_OUT      5'h04
`define OFF_DATA_IN       5'h08
`define OFF_STATUS        5'h0c
`define OFF_BAUD          5'h10
`define MODE_CODE_LSB     0
`define MODE_CODE_MSB     7
`define MODE_MASK_LSB     8
`define MODE_MASK_MSB     15
`define BAUD_RESET        16'h0009
`define SETUP_CYCLES      1
`define STROBE_CYCLES     1
`define RESP_OKAY         2'b00
`define RESP_SLVERR       2'b10
`endif

/* hdl/usb_parallel_bitbang_port.v */
// Byte-wide bit-bang port with asynchronous and synchronous variants, AXI4-Lite registers.
// Assumes one 100 MHz clock; pins come from outside and pass a three-stage synchroniser.
//
// Added by the designer: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "bitbang_consts.vh"
module usb_parallel_bitbang_port
(
   // Clock and reset.
   input  wire        ref_clk,
   input  wire        reset,
   // AXI4-Lite write channels.
   input  wire [4:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   // AXI4-Lite read channels.
   input  wire [4:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   // Parallel pins.
   input  wire [7:0]  pin_in,
   output reg  [7:0]  pin_out,
   output wire [7:0]  pin_oe_n,
   output reg         pin_sample_strobe_n,
   output reg         pin_update_strobe_n
);
   localparam ST_IDLE   = 3'd0;
   localparam ST_SAMPLE = 3'd1;
   localparam ST_SEND   = 3'd2;
   localparam ST_DRIVE  = 3'd3;
   localparam ST_SETUP  = 3'd4;
   localparam ST_STROBE = 3'd5;

   reg  [7:0]  mode_reg;
   reg  [7:0]  dir_reg;
   reg  [15:0] baud_reg;
   reg  [15:0] baud_cnt_reg;
   reg  [7:0]  rx_data_reg;
   reg         rx_full_reg;
   reg  [7:0]  tx_data_reg;
   reg         tx_full_reg;
   reg  [7:0]  sample_reg;
   reg  [2:0]  state_reg;
   reg  [7:0]  sync1_reg;
   reg  [7:0]  sync2_reg;
   reg  [7:0]  sync3_reg;
   reg  [7:0]  pins_reg;
   reg  [7:0]  aw_addr_reg;
   reg         aw_held_reg;
   reg  [31:0] w_data_reg;
   reg  [3:0]  w_strb_reg;
   reg         w_held_reg;
   wire        baud_tick;
   wire        do_write;
   wire        do_read;
   wire        rd_data;
   wire [7:0]  mode_byte;
   wire [7:0]  waddr;

   // Pin synchroniser: a change counts once stages two and three agree.
   genvar i;
   generate
      for (i = 0; i < 8; i = i + 1)
      begin : g_pin
         always @(posedge ref_clk)
         begin
            if (reset)
            begin
               sync1_reg[i] <= 1'b0;
               sync2_reg[i] <= 1'b0;
               sync3_reg[i] <= 1'b0;
               pins_reg[i]  <= 1'b0;
            end
            else
            begin
               sync1_reg[i] <= pin_in[i];
               sync2_reg[i] <= sync1_reg[i];
               sync3_reg[i] <= sync2_reg[i];
               if (sync2_reg[i] == sync3_reg[i])
                  pins_reg[i] <= sync3_reg[i];
            end
         end
         // Active low enable; input pins stay undriven.
         assign pin_oe_n[i] = ~dir_reg[i];
      end
   endgenerate

   // AXI4-Lite write: address and data taken in either order, response after both.
   assign s_axi_awready = ~aw_held_reg & ~s_axi_bvalid;
   assign s_axi_wready  = ~w_held_reg & ~s_axi_bvalid;
   assign do_write      = aw_held_reg & w_held_reg & ~s_axi_bvalid;
   assign waddr         = aw_addr_reg;
   assign mode_byte     = w_data_reg[`MODE_CODE_MSB:`MODE_CODE_LSB];
   assign s_axi_arready = ~s_axi_rvalid;
   assign do_read       = s_axi_arvalid & ~s_axi_rvalid;
   assign rd_data       = do_read & (s_axi_araddr == `OFF_DATA_IN) & tx_full_reg;

   // Baud generator ticks once every baud_reg + 1 cycles.
   assign baud_tick = (baud_cnt_reg == 16'h0000);

   always @(posedge ref_clk)
   begin
      if (reset)
      begin
         aw_held_reg  <= 1'b0;
         aw_addr_reg  <= 8'h00;
         w_held_reg   <= 1'b0;
         w_data_reg   <= 32'h0000_0000;
         w_strb_reg   <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `RESP_OKAY;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp  <= `RESP_OKAY;
         s_axi_rdata  <= 32'h0000_0000;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= {3'b000, s_axi_awaddr};
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_held_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end
         if (do_write)
         begin
            aw_held_reg  <= 1'b0;
            w_held_reg   <= 1'b0;
            s_axi_bvalid <= 1'b1;
            if (waddr == {3'b000, `OFF_MODE} || waddr == {3'b000, `OFF_DATA_OUT} ||
                waddr == {3'b000, `OFF_BAUD})
               s_axi_bresp <= `RESP_OKAY;
            else
               s_axi_bresp <= `RESP_SLVERR;
         end
         else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
         if (do_read)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `RESP_OKAY;
            case (s_axi_araddr)
               `OFF_MODE:     s_axi_rdata <= {16'h0000, dir_reg, mode_reg};
               `OFF_DATA_IN:  s_axi_rdata <= {23'h000000, tx_full_reg, tx_data_reg};
               `OFF_STATUS:   s_axi_rdata <= {22'h000000, pin_update_strobe_n,
                                              pin_sample_strobe_n, pins_reg};
               `OFF_BAUD:     s_axi_rdata <= {16'h0000, baud_reg};
               default:
               begin
                  s_axi_rdata <= 32'h0000_0000;
                  s_axi_rresp <= `RESP_SLVERR;
               end
            endcase
         end
         else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

   // Port engine.
   always @(posedge ref_clk)
   begin
      if (reset || (do_write && waddr == {3'b000, `OFF_MODE} && w_strb_reg[0] &&
                    mode_byte == `MODE_RESET))
      begin
         mode_reg            <= `MODE_RESET;
         dir_reg             <= 8'h00;
         pin_out             <= 8'h00;
         rx_data_reg         <= 8'h00;
         rx_full_reg         <= 1'b0;
         tx_data_reg         <= 8'h00;
         tx_full_reg         <= 1'b0;
         sample_reg          <= 8'h00;
         state_reg           <= ST_IDLE;
         baud_cnt_reg        <= `BAUD_RESET;
         pin_sample_strobe_n <= 1'b1;
         pin_update_strobe_n <= 1'b1;
         if (reset)
            baud_reg <= `BAUD_RESET;
      end
      else
      begin
         if (do_write && waddr == {3'b000, `OFF_MODE} && w_strb_reg[0])
         begin
            mode_reg <= mode_byte;
            if (w_strb_reg[1])
               dir_reg <= w_data_reg[`MODE_MASK_MSB:`MODE_MASK_LSB];
         end
         if (do_write && waddr == {3'b000, `OFF_BAUD})
            baud_reg <= w_data_reg[15:0];
         // Device-bound fifo: one byte; writes while full are dropped.
         if (do_write && waddr == {3'b000, `OFF_DATA_OUT} && w_strb_reg[0] && !rx_full_reg)
         begin
            rx_data_reg <= w_data_reg[7:0];
            rx_full_reg <= 1'b1;
         end
         // Host-bound fifo drains on a read of the data register.
         if (rd_data)
            tx_full_reg <= 1'b0;
         baud_cnt_reg <= baud_tick ? baud_reg : baud_cnt_reg - 16'h0001;
         case (mode_reg)
            `MODE_ASYNC:
            begin
               // Output stage moves a byte only on a tick; strobes pulse one cycle.
               pin_update_strobe_n <= 1'b1;
               pin_sample_strobe_n <= 1'b1;
               if (baud_tick && rx_full_reg)
               begin
                  pin_out             <= rx_data_reg & dir_reg;
                  rx_full_reg         <= 1'b0;
                  pin_update_strobe_n <= 1'b0;
               end
               else if (baud_tick && !tx_full_reg)
               begin
                  tx_data_reg         <= pins_reg;
                  tx_full_reg         <= 1'b1;
                  pin_sample_strobe_n <= 1'b0;
               end
            end
            `MODE_SYNC:
            begin
               case (state_reg)
                  ST_IDLE:
                  begin
                     pin_update_strobe_n <= 1'b1;
                     if (rx_full_reg && !tx_full_reg)
                     begin
                        sample_reg <= pins_reg;
                        state_reg  <= ST_SAMPLE;
                     end
                  end
                  ST_SAMPLE:
                  begin
                     pin_sample_strobe_n <= 1'b1;
                     tx_data_reg         <= sample_reg;
                     tx_full_reg         <= 1'b1;
                     state_reg           <= ST_DRIVE;
                  end
                  ST_DRIVE:
                  begin
                     pin_sample_strobe_n <= 1'b0;
                     pin_out             <= rx_data_reg & dir_reg;
                     rx_full_reg         <= 1'b0;
                     state_reg           <= ST_SETUP;
                  end
                  ST_SETUP:
                  begin
                     pin_update_strobe_n <= 1'b0;
                     state_reg           <= ST_STROBE;
                  end
                  ST_STROBE:
                  begin
                     pin_update_strobe_n <= 1'b1;
                     state_reg           <= ST_IDLE;
                  end
                  default:
                     state_reg <= ST_IDLE;
               endcase
            end
            default:
            begin
               pin_sample_strobe_n <= 1'b1;
               pin_update_strobe_n <= 1'b1;
            end
         endcase
         // A setup command restarts the engine; pins turned to inputs drop their bits.
         if (do_write && waddr == {3'b000, `OFF_MODE} && w_strb_reg[0])
         begin
            state_reg <= ST_IDLE;
            if (w_strb_reg[1])
               pin_out <= pin_out & w_data_reg[`MODE_MASK_MSB:`MODE_MASK_LSB];
         end
      end
   end
endmodule // usb_parallel_bitbang_port

/* dv/bitbang_props.sv */
// Checker for the bit-bang port: pin strobes, pin data and bus handshakes.
// Assumes binding to the port module; sees its ports only.
`timescale 1ns/1ps
module bitbang_props
(
   // Clock and reset.
   input wire        ref_clk,
   input wire        reset,
   // Bus.
   input wire        s_axi_awready,
   input wire        s_axi_wready,
   input wire [1:0]  s_axi_bresp,
   input wire        s_axi_bvalid,
   input wire        s_axi_bready,
   input wire        s_axi_arvalid,
   input wire        s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire        s_axi_rvalid,
   input wire        s_axi_rready,
   // Pins.
   input wire [7:0]  pin_out,
   input wire [7:0]  pin_oe_n,
   input wire        pin_sample_strobe_n,
   input wire        pin_update_strobe_n
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);
   sequence s_upd_pulse;
      !pin_update_strobe_n ##1 pin_update_strobe_n;
   endsequence
   property p_upd_pulse;
      $fell(pin_update_strobe_n) |-> s_upd_pulse;
   endproperty
   property p_sync_order;
      $fell(pin_update_strobe_n) && !pin_sample_strobe_n
         |-> $past(pin_sample_strobe_n, 2) && !$past(pin_sample_strobe_n);
   endproperty
   property p_wr_setup;
      !pin_update_strobe_n && !pin_sample_strobe_n |-> $stable(pin_out);
   endproperty
   property p_out_masked;
      $stable(pin_oe_n) |-> (pin_out & pin_oe_n) == 8'h00;
   endproperty
   property p_out_hold;
      $changed(pin_out) && $stable(pin_oe_n)
         |-> !pin_update_strobe_n or ##1 !pin_update_strobe_n;
   endproperty
   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   property p_r_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   property p_w_refuse;
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
   endproperty
   property p_ar_answer;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
   endproperty
   a_upd_pulse: assert property (p_upd_pulse)
      else $error("update strobe not one cycle");
   a_sync_order: assert property (p_sync_order)
      else $error("sample strobe order wrong");
   a_wr_setup: assert property (p_wr_setup)
      else $error("pins moved under update strobe");
   a_out_masked: assert property (p_out_masked)
      else $error("input pin driven");
   a_out_hold: assert property (p_out_hold)
      else $error("pins moved without update strobe");
   a_b_hold: assert property (p_b_hold)
      else $error("write response dropped");
   a_r_hold: assert property (p_r_hold)
      else $error("read response dropped");
   a_w_refuse: assert property (p_w_refuse)
      else $error("write taken while response held");
   a_ar_answer: assert property (p_ar_answer)
      else $error("read answer late");
endmodule // bitbang_props
bind usb_parallel_bitbang_port bitbang_props u_bitbang_props (.ref_clk, .reset,
   .s_axi_awready, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
   .pin_out, .pin_oe_n, .pin_sample_strobe_n, .pin_update_strobe_n);

/* dv/pin_logic_model.sv */
// External logic on the pins: drives input pins, counts update strobes.
// Assumes the bench gives the level of the input pins.
`timescale 1ns/1ps
module pin_logic_model
(
   // Port pins.
   input  wire [7:0] pin_out,
   input  wire [7:0] pin_oe_n,
   input  wire       pin_update_strobe_n,
   output wire [7:0] pin_in,
   // Bench side.
   input  wire [7:0] ext_level,
   output reg  [7:0] update_count
);
   assign pin_in = (pin_out & ~pin_oe_n) | (ext_level & pin_oe_n);
   initial update_count = 8'h00;
   always @(posedge pin_update_strobe_n)
      update_count <= update_count + 8'h01;
endmodule // pin_logic_model

/* dv/usb_parallel_bitbang_port_test.sv */
// Testbench of the bit-bang port with a reference model of the pins.
// Assumes the design constants header and the pin logic model.
`timescale 1ns/1ps
`include "bitbang_consts.vh"
module usb_parallel_bitbang_port_test;
   reg         ref_clk = 1'b0;
   reg         reset = 1'b1;
   reg  [4:0]  s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
   reg  [31:0] s_axi_wdata = 32'h0, seed = 32'h80977559, q;
   reg  [3:0]  s_axi_wstrb = 4'hf;
   reg         s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   reg         s_axi_arvalid = 0, s_axi_rready = 0;
   wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire [1:0]  s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire [7:0]  pin_in, pin_out, pin_oe_n, update_count;
   wire        pin_sample_strobe_n, pin_update_strobe_n;
   reg  [7:0]  ext_level = 8'h00, mask = 8'h00, cur, cnt0;
   reg  [1:0]  r;
   reg  [7:0]  exp_q[$];
   integer     errors = 0, tests_run = 0, i, p;
   always #5 ref_clk = ~ref_clk;
   usb_parallel_bitbang_port u_usb_parallel_bitbang_port (.ref_clk, .reset, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pin_in, .pin_out, .pin_oe_n,
      .pin_sample_strobe_n, .pin_update_strobe_n);
   pin_logic_model u_pin_logic_model (.pin_out, .pin_oe_n, .pin_update_strobe_n, .pin_in,
      .ext_level, .update_count);
   function [31:0] xs(input [31:0] x);
      reg [31:0] y;
      begin
         y = x ^ (x << 13);
         y = y ^ (y >> 17);
         xs = y ^ (y << 5);
      end
   endfunction
   task check(input [31:0] seen, input [31:0] expv);
      begin
         tests_run = tests_run + 1;
         if (seen !== expv)
         begin
            errors = errors + 1;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, expv);
         end
      end
   endtask
   task conclude;
      begin
         if (errors == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
         else
            $display("TESTS FAILED");
         $finish;
      end
   endtask
   task bus(input wr, input [4:0] a, input [31:0] d);
      reg [3:0] t;
      integer   n;
      begin
         t = 4'h0;
         n = 0;
         @(posedge ref_clk);
         s_axi_awaddr <= a;
         s_axi_araddr <= a;
         s_axi_wdata <= d;
         {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{wr}};
         {s_axi_arvalid, s_axi_rready} <= {2{!wr}};
         while (!t[0] && n < 50)
         begin
            @(posedge ref_clk);
            n = n + 1;
            t = {s_axi_awvalid & s_axi_awready, s_axi_wvalid & s_axi_wready,
               s_axi_arvalid & s_axi_arready,
               (s_axi_bvalid & s_axi_bready) | (s_axi_rvalid & s_axi_rready)};
            q = s_axi_rdata;
            r = wr ? s_axi_bresp : s_axi_rresp;
            s_axi_awvalid <= s_axi_awvalid & ~t[3];
            s_axi_wvalid <= s_axi_wvalid & ~t[2];
            s_axi_arvalid <= s_axi_arvalid & ~t[1];
            s_axi_bready <= s_axi_bready & ~t[0];
            s_axi_rready <= s_axi_rready & ~t[0];
         end
         check(t[0], 1'b1);
      end
   endtask
   task setmode(input [7:0] code);
      bus(1, `OFF_MODE, {16'h0, mask, code});
   endtask
   task get;
      integer n;
      begin
         n = 0;
         q = 32'h0;
         while (!q[8] && n < 20)
         begin
            bus(0, `OFF_DATA_IN, 0);
            n = n + 1;
         end
         check(q[8:0], {1'b1, exp_q.pop_front()});
      end
   endtask
   initial
   begin
      repeat (30000) @(posedge ref_clk);
      errors = errors + 1;
      conclude;
   end
   initial
   begin
      repeat (4) @(posedge ref_clk);
      reset <= 1'b0;
      check({pin_oe_n, pin_out, pin_sample_strobe_n, pin_update_strobe_n}, 18'h3fc03);
      bus(0, `OFF_BAUD, 0);
      check(q, `BAUD_RESET);
      bus(0, 5'h14, 0);
      check(r, `RESP_SLVERR);
      check(q, 32'h0);
      bus(1, 5'h18, 0);
      check(r, `RESP_SLVERR);
      bus(1, `OFF_BAUD, 32'h3);
      cur = 8'h00;
      for (p = 0; p < 2; p = p + 1)
      begin
         seed = xs(seed);
         mask = p ? 8'h00 : seed[7:0];
         ext_level <= seed[15:8];
         setmode(`MODE_SYNC);
         cur = cur & mask;
         check({24'h0, pin_oe_n}, {24'h0, ~mask});
         bus(0, `OFF_MODE, 0);
         check(q, {16'h0, mask, `MODE_SYNC});
         for (i = 0; i < 3; i = i + 1)
         begin
            seed = xs(seed);
            repeat (12) @(posedge ref_clk);
            exp_q.push_back((cur & mask) | (ext_level & ~mask));
            bus(1, `OFF_DATA_OUT, seed[7:0]);
            repeat (12) @(posedge ref_clk);
            bus(1, `OFF_DATA_OUT, seed[15:8]);
            repeat (12) @(posedge ref_clk);
            bus(0, `OFF_STATUS, 0);
            check(q[9:0], {2'b10, (seed[7:0] & mask) | (ext_level & ~mask)});
            check(pin_out, seed[7:0] & mask);
            cur = seed[7:0] & mask;
            exp_q.push_back((cur & mask) | (ext_level & ~mask));
            get;
            get;
            repeat (12) @(posedge ref_clk);
            check(pin_out, seed[15:8] & mask);
            cur = seed[15:8] & mask;
            ext_level <= seed[23:16];
         end
      end
      setmode(`MODE_RESET);
      check({pin_oe_n, pin_out}, 16'hff00);
      seed = xs(seed);
      mask = seed[7:0] | 8'h01;
      setmode(`MODE_ASYNC);
      cnt0 = update_count;
      for (i = 0; i < 3; i = i + 1)
      begin
         seed = xs(seed);
         bus(1, `OFF_DATA_OUT, seed[7:0]);
         repeat (20) @(posedge ref_clk);
         check(pin_out, seed[7:0] & mask);
      end
      check(update_count - cnt0, 8'h03);
      conclude;
   end
endmodule // usb_parallel_bitbang_port_test
